// *** rtl/eas_pkg.sv ***
// Package with constants and carrier types of the event/action sequencer.
package eas_pkg;

  localparam int unsigned NUM_SLOTS     = 20;
  localparam int unsigned IDX_W         = 5;
  localparam int unsigned CODE_W        = 8;
  localparam int unsigned PCT_W         = 7;
  localparam int unsigned REF_W         = 16;
  localparam int unsigned DIN_N         = 2;
  localparam int unsigned TMR_W         = 32;

  // Scan tick: one evaluation per period of the control clock divider.
  localparam int unsigned CLK_HZ        = 250000000;
  localparam int unsigned SCAN_US       = 1;
  localparam int unsigned SCAN_CYC      = (CLK_HZ / 1000000) * SCAN_US;
  localparam int unsigned SCAN_W        = 8;

  // Timer 0 unit: milliseconds, default duration as in the example.
  localparam int unsigned TMR_MS_CYC    = CLK_HZ / 1000;
  localparam int unsigned TMR0_MS_RST   = 2000;
  localparam int unsigned MS_W          = 18;

  // Ramp step per scan tick for reference output.
  localparam logic [REF_W-1:0] RAMP_STEP = 16'h0001;

  // Event codes.
  localparam logic [CODE_W-1:0] EV_FALSE   = 8'h00;
  localparam logic [CODE_W-1:0] EV_TRUE    = 8'h01;
  localparam logic [CODE_W-1:0] EV_ON_REF  = 8'h04;
  localparam logic [CODE_W-1:0] EV_TMR0_TO = 8'h1e;
  localparam logic [CODE_W-1:0] EV_EXT     = 8'h40;

  // Action codes.
  localparam logic [CODE_W-1:0] AC_NONE    = 8'h01;
  localparam logic [CODE_W-1:0] AC_PRESET0 = 8'h0a;
  localparam logic [CODE_W-1:0] AC_PRESET1 = 8'h0b;
  localparam logic [CODE_W-1:0] AC_TMR0    = 8'h1d;

  // Digital input function codes.
  localparam logic [CODE_W-1:0] DI_NOP     = 8'h00;
  localparam logic [CODE_W-1:0] DI_STOP_N  = 8'h06;
  localparam logic [CODE_W-1:0] DI_START   = 8'h08;
  localparam logic [CODE_W-1:0] DI_LATCH   = 8'h09;

  // Register map, word indexes times four.
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_COUNT   = 8'h04;
  localparam logic [7:0] A_TMR0    = 8'h08;
  localparam logic [7:0] A_PRESET0 = 8'h0c;
  localparam logic [7:0] A_PRESET1 = 8'h10;
  localparam logic [7:0] A_MAXREF  = 8'h14;
  localparam logic [7:0] A_DIFUNC  = 8'h18;
  localparam logic [7:0] A_STATUS  = 8'h1c;
  localparam logic [7:0] A_EVENT   = 8'h40;
  localparam logic [7:0] A_ACTION  = 8'h90;

  typedef enum logic [1:0] {
    EAS_DRV_FREE = 2'b00,
    EAS_DRV_RUN  = 2'b01,
    EAS_DRV_RAMP = 2'b10
  } eas_drv_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } eas_bus_req_t;

  typedef struct packed {
    logic [REF_W-1:0] ref_val;
    logic             running;
    logic             free;
    logic             preset_sel;
    logic             tmr0_run;
  } eas_drive_out_t;

endpackage : eas_pkg

// *** rtl/eas_sequencer.sv ***
// Event/action sequencer with timer 0, digital input functions and reference ramp.
// Functional notes
// - Events and actions are numbered pairs; a true event n runs action n.
// - Only the current state's event is tested in any scan interval.
// - A false event leaves state unchanged, no action, retest next scan.
// - After an action the next numbered state's event is tested.
// - The pair count is programmable from zero to twenty.
// - After the last pair the sequence wraps to the first pair.
// - Nothing is tested or performed while the mode setting is off.
// - Event codes: 0 false, 1 true, 4 on reference, 30 timer 0 expired.
// - Action codes: 1 none, 10 preset 0, 11 preset 1, 29 start timer 0.
// - Timer 0 runs its programmed duration, then raises time-out.
// - Events come from external inputs and from internal conditions.
// - Input functions: 0 none, 8 start/stop, 9 latched start, 6 stop low.
// - A stop ramps the output down and then the drive goes free.
// - Preset references are percentages of the maximum reference.
//
// Strobed register access and the address map were decided locally.
module eas_sequencer (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_b_i,
  input  wire eas_pkg::eas_bus_req_t      bus_i,
  output logic [31:0]                     rdata_o,
  input  wire logic [eas_pkg::DIN_N-1:0]  din_i,
  input  wire logic [7:0]                 ext_event_i,
  output eas_pkg::eas_drive_out_t         drive_o
);

  typedef struct packed {
    logic                             mode_on;
    logic                             mode_on_d;
    logic [eas_pkg::IDX_W-1:0]        count;
    logic [eas_pkg::IDX_W-1:0]        idx;
    logic [eas_pkg::NUM_SLOTS-1:0][eas_pkg::CODE_W-1:0] ev;
    logic [eas_pkg::NUM_SLOTS-1:0][eas_pkg::CODE_W-1:0] ac;
    logic [eas_pkg::PCT_W-1:0]        preset0;
    logic [eas_pkg::PCT_W-1:0]        preset1;
    logic [eas_pkg::REF_W-1:0]        max_ref;
    logic [eas_pkg::DIN_N-1:0][eas_pkg::CODE_W-1:0] di_func;
    logic [eas_pkg::MS_W-1:0]         tmr0_ms;
    logic [eas_pkg::SCAN_W-1:0]       scan_cnt;
    logic                             tmr0_run;
    logic                             tmr0_to;
    logic [eas_pkg::MS_W-1:0]         tmr0_left;
    logic [eas_pkg::TMR_W-1:0]        ms_cnt;
    logic                             preset_sel;
    logic [eas_pkg::DIN_N-1:0]        din_s1;
    logic [eas_pkg::DIN_N-1:0]        din_s2;
    logic                             latched;
    eas_pkg::eas_drv_t                drv;
    logic [eas_pkg::REF_W-1:0]        out_ref;
    logic [31:0]                      rdata;
  } eas_state_t;

  eas_state_t st;
  eas_state_t next_st;

  // Target reference from a percentage of the maximum reference.
  function automatic logic [eas_pkg::REF_W-1:0] pct_of(
    input logic [eas_pkg::PCT_W-1:0] pct,
    input logic [eas_pkg::REF_W-1:0] maxr
  );
    logic [eas_pkg::REF_W+eas_pkg::PCT_W-1:0] prod;
    prod   = maxr * pct;
    pct_of = eas_pkg::REF_W'(prod / 100);
  endfunction : pct_of

  logic                        scan_tick;
  logic                        ev_true;
  logic [eas_pkg::CODE_W-1:0]  cur_ev;
  logic [eas_pkg::CODE_W-1:0]  cur_ac;
  logic                        run_cmd;
  logic                        stop_cmd;
  logic [eas_pkg::REF_W-1:0]   target;
  logic                        on_ref;
  logic [5:0]                  slot_w;

  assign scan_tick = (st.scan_cnt == eas_pkg::SCAN_W'(eas_pkg::SCAN_CYC - 1));
  assign cur_ev    = st.ev[st.idx];
  assign cur_ac    = st.ac[st.idx];
  assign target    = st.preset_sel ? pct_of(st.preset1, st.max_ref)
                                   : pct_of(st.preset0, st.max_ref);
  assign on_ref    = (st.drv == eas_pkg::EAS_DRV_RUN) && (st.out_ref == target);
  assign drive_o   = '{ref_val:    st.out_ref,
                       running:    st.drv == eas_pkg::EAS_DRV_RUN,
                       free:       st.drv == eas_pkg::EAS_DRV_FREE,
                       preset_sel: st.preset_sel,
                       tmr0_run:   st.tmr0_run};
  assign rdata_o   = st.rdata;

  // Decode of the current event: internal conditions and external flags both count.
  always_comb begin
    case (cur_ev)
      eas_pkg::EV_FALSE:   ev_true = 1'b0;
      eas_pkg::EV_TRUE:    ev_true = 1'b1;
      eas_pkg::EV_ON_REF:  ev_true = on_ref;
      eas_pkg::EV_TMR0_TO: ev_true = st.tmr0_to;
      default: begin
        // Codes from the external base up to base plus seven test an outside flag.
        if (cur_ev >= eas_pkg::EV_EXT && cur_ev < eas_pkg::EV_EXT + 8'h08) begin
          ev_true = ext_event_i[cur_ev[2:0]];
        end else begin
          ev_true = 1'b0;
        end
      end
    endcase
  end

  // Start and stop requests gathered from the configured input terminals.
  always_comb begin
    run_cmd  = 1'b0;
    stop_cmd = 1'b0;
    for (int i = 0; i < eas_pkg::DIN_N; i++) begin
      case (st.di_func[i])
        eas_pkg::DI_START:  begin
          if (st.din_s2[i]) begin
            run_cmd = 1'b1;
          end else begin
            stop_cmd = 1'b1;
          end
        end
        eas_pkg::DI_LATCH:  begin
          if (st.din_s2[i]) begin
            run_cmd = 1'b1;
          end
        end
        eas_pkg::DI_STOP_N: begin
          if (!st.din_s2[i]) begin
            stop_cmd = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign slot_w = 6'(bus_i.addr[7:2] - eas_pkg::A_EVENT[7:2]);

  // Whole next-state computation of the block.
  always_comb begin
    logic [5:0] aslot;
    aslot   = 6'(bus_i.addr[7:2] - eas_pkg::A_ACTION[7:2]);
    next_st = st;

    next_st.din_s1 = din_i;
    next_st.din_s2 = st.din_s1;
    next_st.scan_cnt = scan_tick ? '0 : st.scan_cnt + 1'b1;

    // Register writes.
    if (bus_i.wr) begin
      case (bus_i.addr)
        eas_pkg::A_CTRL:    next_st.mode_on = bus_i.wdata[0];
        eas_pkg::A_COUNT:   begin
          // Counts above the maximum are clamped; the table has only twenty slots.
          if (bus_i.wdata[7:0] > 8'(eas_pkg::NUM_SLOTS)) begin
            next_st.count = eas_pkg::IDX_W'(eas_pkg::NUM_SLOTS);
          end else begin
            next_st.count = bus_i.wdata[eas_pkg::IDX_W-1:0];
          end
        end
        eas_pkg::A_TMR0:    next_st.tmr0_ms = bus_i.wdata[eas_pkg::MS_W-1:0];
        eas_pkg::A_PRESET0: next_st.preset0 = bus_i.wdata[eas_pkg::PCT_W-1:0];
        eas_pkg::A_PRESET1: next_st.preset1 = bus_i.wdata[eas_pkg::PCT_W-1:0];
        eas_pkg::A_MAXREF:  next_st.max_ref = bus_i.wdata[eas_pkg::REF_W-1:0];
        eas_pkg::A_DIFUNC:  begin
          next_st.di_func[0] = bus_i.wdata[7:0];
          next_st.di_func[1] = bus_i.wdata[15:8];
        end
        default: begin
          if (slot_w < 6'(eas_pkg::NUM_SLOTS)) begin
            next_st.ev[slot_w[4:0]] = bus_i.wdata[eas_pkg::CODE_W-1:0];
          end else if (aslot < 6'(eas_pkg::NUM_SLOTS)) begin
            next_st.ac[aslot[4:0]] = bus_i.wdata[eas_pkg::CODE_W-1:0];
          end
        end
      endcase
    end

    // Register reads, answered in the next cycle; unmapped reads give zero.
    next_st.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        eas_pkg::A_CTRL:    next_st.rdata = {31'h0, st.mode_on};
        eas_pkg::A_COUNT:   next_st.rdata = {27'h0, st.count};
        eas_pkg::A_TMR0:    next_st.rdata = {14'h0, st.tmr0_ms};
        eas_pkg::A_PRESET0: next_st.rdata = {25'h0, st.preset0};
        eas_pkg::A_PRESET1: next_st.rdata = {25'h0, st.preset1};
        eas_pkg::A_MAXREF:  next_st.rdata = {16'h0, st.max_ref};
        eas_pkg::A_DIFUNC:  next_st.rdata = {16'h0, st.di_func[1], st.di_func[0]};
        eas_pkg::A_STATUS:  next_st.rdata = {st.out_ref, 6'h0, st.drv, st.latched,
                                             st.tmr0_to, st.tmr0_run, st.idx};
        default: begin
          if (slot_w < 6'(eas_pkg::NUM_SLOTS)) begin
            next_st.rdata = {24'h0, st.ev[slot_w[4:0]]};
          end else if (aslot < 6'(eas_pkg::NUM_SLOTS)) begin
            next_st.rdata = {24'h0, st.ac[aslot[4:0]]};
          end
        end
      endcase
    end

    // Timer 0 counts whole milliseconds and flags time-out when it ends.
    if (st.tmr0_run) begin
      if (st.ms_cnt == eas_pkg::TMR_W'(eas_pkg::TMR_MS_CYC - 1)) begin
        next_st.ms_cnt = '0;
        if (st.tmr0_left <= eas_pkg::MS_W'(1)) begin
          next_st.tmr0_run = 1'b0;
          next_st.tmr0_to  = 1'b1;
        end else begin
          next_st.tmr0_left = st.tmr0_left - 1'b1;
        end
      end else begin
        next_st.ms_cnt = st.ms_cnt + 1'b1;
      end
    end

    // Sequencer: a rising mode forces the first pair before any scan.
    next_st.mode_on_d = st.mode_on;
    if (st.mode_on && !st.mode_on_d) begin
      next_st.idx = '0;
    end else if (st.mode_on && scan_tick && st.count != '0) begin
      if (ev_true) begin
        case (cur_ac)
          eas_pkg::AC_PRESET0: next_st.preset_sel = 1'b0;
          eas_pkg::AC_PRESET1: next_st.preset_sel = 1'b1;
          eas_pkg::AC_TMR0: begin
            // A restart reloads the duration and clears an old time-out.
            next_st.tmr0_run  = 1'b1;
            next_st.tmr0_to   = 1'b0;
            next_st.tmr0_left = st.tmr0_ms;
            next_st.ms_cnt    = '0;
          end
          default: begin
          end
        endcase
        if (st.idx >= st.count - 1'b1) begin
          next_st.idx = '0;
        end else begin
          next_st.idx = st.idx + 1'b1;
        end
      end
    end

    // Run state of the drive: stop ramps down, then the output goes free.
    if (stop_cmd) begin
      next_st.latched = 1'b0;
    end else if (run_cmd) begin
      next_st.latched = 1'b1;
    end
    case (st.drv)
      eas_pkg::EAS_DRV_FREE: begin
        next_st.out_ref = '0;
        if (run_cmd && !stop_cmd) begin
          next_st.drv = eas_pkg::EAS_DRV_RUN;
        end
      end
      eas_pkg::EAS_DRV_RUN: begin
        if (stop_cmd || !st.latched) begin
          next_st.drv = eas_pkg::EAS_DRV_RAMP;
        end else if (scan_tick && st.out_ref < target) begin
          next_st.out_ref = st.out_ref + eas_pkg::RAMP_STEP;
        end else if (scan_tick && st.out_ref > target) begin
          next_st.out_ref = st.out_ref - eas_pkg::RAMP_STEP;
        end
      end
      eas_pkg::EAS_DRV_RAMP: begin
        if (st.out_ref == '0) begin
          next_st.drv = eas_pkg::EAS_DRV_FREE;
        end else if (scan_tick) begin
          next_st.out_ref = st.out_ref - eas_pkg::RAMP_STEP;
        end
      end
      default: next_st.drv = eas_pkg::EAS_DRV_FREE;
    endcase
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st          <= '0;
      st.tmr0_ms  <= eas_pkg::MS_W'(eas_pkg::TMR0_MS_RST);
      st.drv      <= eas_pkg::EAS_DRV_FREE;
    end else begin
      st <= next_st;
    end
  end

endmodule : eas_sequencer

// *** sim/eas_drive_model.sv ***
// Model of the drive-side sources: digital input terminals and external event flags.
module eas_drive_model (
  input  wire logic                       core_clk_i,
  input  wire logic [eas_pkg::DIN_N-1:0]  din_cmd_i,
  input  wire logic [7:0]                 ev_cmd_i,
  output logic [eas_pkg::DIN_N-1:0]       din_o,
  output logic [7:0]                      ext_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels start low so the design never sees an unknown terminal.
  initial begin
    din_o = '0;
    ext_event_o = '0;
  end
  // Sources change just after an edge and hold as levels until withdrawn.
  always @(posedge core_clk_i) begin
    din_o <= din_cmd_i;
    ext_event_o <= ev_cmd_i;
  end
endmodule : eas_drive_model

// *** sim/eas_monitor.sv ***
// Checker of port-level behaviour of the event/action sequencer.
module eas_monitor (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_b_i,
  input  wire eas_pkg::eas_bus_req_t      bus_i,
  input  wire logic [31:0]                rdata_o,
  input  wire logic [eas_pkg::DIN_N-1:0]  din_i,
  input  wire logic [7:0]                 ext_event_i,
  input  wire eas_pkg::eas_drive_out_t    drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Ramp-down phase, used by one property, and reference steps, shared by two properties.
  sequence s_ramp;
    !drive_o.running && !drive_o.free;
  endsequence
  sequence s_step;
    $changed(drive_o.ref_val);
  endsequence
  // Read data must be quiet unless it answers a read.
  rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 32'h0)
    else $error("read data seen outside a read reply");
  free_zero_a: assert property (drive_o.free |-> drive_o.ref_val == 16'h0)
    else $error("drive free with nonzero reference");
  // The drive may only fall free out of the ramp-down phase, never straight from running.
  run_free_a: assert property ($rose(drive_o.free) |-> $past(!drive_o.running))
    else $error("drive went free without ramping down");
  ramp_down_a: assert property (s_ramp ##1 s_ramp |->
    drive_o.ref_val <= $past(drive_o.ref_val))
    else $error("reference rose during ramp down");
  ref_step_a: assert property (s_step |->
    drive_o.ref_val == $past(drive_o.ref_val) + 16'h1 ||
    drive_o.ref_val == $past(drive_o.ref_val) - 16'h1)
    else $error("reference moved by more than one step");
  ref_pace_a: assert property (s_step |=> $stable(drive_o.ref_val) [*8])
    else $error("reference stepped twice in one scan");
  preset_pace_a: assert property ($changed(drive_o.preset_sel) |=>
    $stable(drive_o.preset_sel) [*8])
    else $error("preset selection changed twice in one scan");
  tmr_hold_a: assert property ($rose(drive_o.tmr0_run) |=> drive_o.tmr0_run [*8])
    else $error("timer stopped right after start");
  one_action_a: assert property ($rose(drive_o.tmr0_run) |-> $stable(drive_o.preset_sel))
    else $error("two actions in one scan");
endmodule : eas_monitor

bind eas_sequencer eas_monitor u_mon (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .din_i(din_i), .ext_event_i(ext_event_i), .drive_o(drive_o));

// *** sim/eas_sequencer_bench.sv ***
// Self-checking bench of the event/action sequencer.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module eas_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} eas_row_t;
  logic                    core_clk_i = 1'b0;
  logic                    rst_b_i    = 1'b0;
  eas_pkg::eas_bus_req_t   bus        = '0;
  logic [31:0]             rdata;
  logic [31:0]             d;
  logic [1:0]              din_cmd    = '0;
  logic [1:0]              din;
  logic [7:0]              ev_cmd     = '0;
  logic [7:0]              ext;
  eas_pkg::eas_drive_out_t drv;
  int                      errors     = 0;
  int                      check_count = 0;
  int                      n;
  // Register rows: address, value written, value read back.
  eas_row_t rows [8] = '{'{eas_pkg::A_COUNT, 32'h19, 32'h14}, '{eas_pkg::A_COUNT, 32'h0, 32'h0},
    '{eas_pkg::A_TMR0, 32'h1, 32'h1}, '{eas_pkg::A_PRESET0, 32'h0, 32'h0},
    '{eas_pkg::A_PRESET1, 32'h32, 32'h32}, '{eas_pkg::A_MAXREF, 32'h14, 32'h14},
    '{8'h4c, 32'h0, 32'h0}, '{8'h3c, 32'hff, 32'h0}};

  // Clock of 4 ns period.
  always #2 core_clk_i = ~core_clk_i;

  eas_drive_model u_far (.core_clk_i(core_clk_i), .din_cmd_i(din_cmd), .ev_cmd_i(ev_cmd),
    .din_o(din), .ext_event_o(ext));
  eas_sequencer dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
    .din_i(din), .ext_event_i(ext), .drive_o(drv));

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge core_clk_i) bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i) bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Scan ticks are 250 cycles apart, so the poll is bounded well beyond a few ticks.
  task automatic wait_idx(input logic [4:0] e);
    n = 0;
    do begin
      rd(eas_pkg::A_STATUS);
      n++;
    end while (d[4:0] !== e && n < 3000);
    // A poll that runs out leaves the wrong index here and counts as a mismatch.
    `CHK("state index", e, d[4:0])
  endtask : wait_idx

  task automatic wait_free();
    n = 0;
    while (drv.free !== 1'b1 && n < 20000) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK("drive free", 1'b1, drv.free)
  endtask : wait_free

  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Watchdog sized far above the expected run of about 8000 cycles.
  initial begin
    #400000;
    errors++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(eas_pkg::A_TMR0);
    `CHK("timer default", 32'h7d0, d)
    `CHK("free at reset", 1'b1, drv.free)
    @(posedge core_clk_i) din_cmd <= 2'b01;
    repeat (20) @(posedge core_clk_i);
    `CHK("no-op input", 1'b0, drv.running)
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `CHK("register row", rows[i].e, d)
    end
    wr(eas_pkg::A_EVENT, 32'h1);
    wr(eas_pkg::A_ACTION, 32'h0b);
    wr(eas_pkg::A_EVENT + 8'h4, 32'h4);
    wr(eas_pkg::A_ACTION + 8'h4, 32'h1d);
    wr(eas_pkg::A_EVENT + 8'h8, 32'h40);
    wr(eas_pkg::A_ACTION + 8'h8, 32'h0a);
    wr(eas_pkg::A_COUNT, 32'h3);
    wr(eas_pkg::A_DIFUNC, 32'h8);
    wr(eas_pkg::A_CTRL, 32'h1);
    wait_idx(5'h1);
    `CHK("first action", 1'b1, drv.preset_sel)
    wait_idx(5'h2);
    `CHK("percent of max", 16'(20 * 50 / 100), drv.ref_val)
    `CHK("timer start", 1'b1, drv.tmr0_run)
    repeat (600) @(posedge core_clk_i);
    rd(eas_pkg::A_STATUS);
    `CHK("false event holds", 5'h2, d[4:0])
    @(posedge core_clk_i) ev_cmd <= 8'h01;
    wait_idx(5'h0);
    `CHK("wrap after last", 1'b0, drv.preset_sel)
    wait_idx(5'h1);
    @(posedge core_clk_i) ev_cmd <= 8'h00;
    wr(eas_pkg::A_CTRL, 32'h0);
    wr(eas_pkg::A_EVENT, 32'h0);
    repeat (600) @(posedge core_clk_i);
    rd(eas_pkg::A_STATUS);
    `CHK("mode off", 5'h1, d[4:0])
    wr(eas_pkg::A_CTRL, 32'h1);
    repeat (600) @(posedge core_clk_i);
    rd(eas_pkg::A_STATUS);
    `CHK("mode on restart", 5'h0, d[4:0])
    @(posedge core_clk_i) din_cmd <= 2'b00;
    wait_free();
    `CHK("stop to free", 16'h0, drv.ref_val)
    wr(eas_pkg::A_DIFUNC, 32'h0609);
    @(posedge core_clk_i) din_cmd <= 2'b11;
    repeat (10) @(posedge core_clk_i);
    din_cmd <= 2'b10;
    repeat (20) @(posedge core_clk_i);
    `CHK("latched start", 1'b1, drv.running)
    din_cmd <= 2'b00;
    wait_free();
    `CHK("inverse stop", 1'b1, drv.free)
    // A reset in mid-run must bring back the defaults and stop the running timer.
    @(posedge core_clk_i) rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(eas_pkg::A_TMR0);
    `CHK("timer default again", 32'h7d0, d)
    rd(eas_pkg::A_STATUS);
    `CHK("status after reset", 32'h0, d)
    give_verdict();
  end
endmodule : eas_sequencer_bench
